//--- rtl/shcp_params.svh
// named constants of the serial host command port.
// assumes inclusion by bare name from the design files.
`ifndef SHCP_PARAMS_SVH
`define SHCP_PARAMS_SVH

// ***************************************************
// command codes
// ***************************************************
`define CMD_DEACTIVATE 8'h00
`define CMD_SOFT_RESET 8'h02
`define CMD_HARD_RESET 8'h04
`define CMD_NO_OP 8'h06
`define CMD_ACTIVATE 8'h0e
`define CMD_TX_SLOT 8'h40
`define CMD_RX_SLOT 8'h42
`define CMD_CLK_SLOT 8'h44
`define CMD_CHIP_CFG 8'h46
`define CMD_CHAN_EN 8'h4a

// ***************************************************
// field positions and reset values
// ***************************************************
`define DIR_BIT 0
`define SIGNALING_BIT 5
`define CHAN_EN_MSB 3
`define CHAN_EN_LSB 0
`define CLK_SLOT_RST 8'h00
`define CHIP_CFG_RST 8'h9a
`define CHAN_EN_RST 8'h0f
`define READ_EMPTY 8'h00

// ***************************************************
// edge counts and timing
// ***************************************************
`define EDGES_PER_BYTE 5'h08
`define EDGES_FOR_RESET 5'h10
`define EDGE_CNT_ZERO 5'h00
`define BIT_IDX_LAST 3'h7
`define BIT_IDX_ZERO 3'h0
`define CLEAR_HOLD_CYCLES 2'h2
`define FS_PULSES_TO_VALID 2'h3
`define CHANNELS 4

`endif

//--- rtl/shcp_pkg.sv
// types shared by the serial host command port.
// assumes nothing beyond a SystemVerilog compiler.
package shcp_pkg;

  typedef enum logic [1:0] {
    ST_CMD   = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b10
  } port_state_e;

  typedef logic [3:0][7:0] slot_arr_t;
  typedef logic [3:0] chan_mask_t;

endpackage

//--- rtl/serial_host_command_port.sv
// serial host command port: byte framing on the shift clock, command
// decoding and the per-channel / global configuration it steers.
// assumes ref_clk_i at 50 MHz, a host that keeps chip select high for at
// least seven ref_clk_i cycles between windows, and an external pad that
// resolves the data pin from its output enable.
`timescale 1ns/10ps
`include "shcp_params.svh"

module serial_host_command_port (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic serial_shift_clock_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  input wire logic frame_sync_i,
  output shcp_pkg::slot_arr_t tx_time_slot_o,
  output shcp_pkg::slot_arr_t rx_time_slot_o,
  output logic [7:0] clock_slot_cfg_o,
  output logic [7:0] chip_cfg_o,
  output logic [7:0] chan_enable_mode_o,
  output shcp_pkg::chan_mask_t channel_active_status_o,
  output shcp_pkg::chan_mask_t pcm_input_enable_o,
  output shcp_pkg::chan_mask_t pcm_output_hiz_o,
  output shcp_pkg::chan_mask_t pcm_tx_valid_o,
  output shcp_pkg::chan_mask_t analog_output_enable_o,
  output logic hard_reset_o
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic [4:0] edge_cnt_q;
  logic [7:0] shift_q;
  logic [2:0] bit_idx_q;
  logic clear_q;
  logic [1:0] clear_cnt_q;
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic fs_meta_q;
  logic fs_sync_q;
  logic fs_prev_q;
  logic hard_rst_q;
  logic core_rst;
  logic win_end;
  logic byte_done;
  logic fs_rise;
  logic [7:0] byte_q;
  logic byte_valid_q;
  shcp_pkg::port_state_e state_q;
  shcp_pkg::port_state_e state_d;
  logic [7:0] cmd_q;
  logic [7:0] tx_byte_q;
  shcp_pkg::slot_arr_t tts_q;
  shcp_pkg::slot_arr_t rts_q;
  logic [7:0] clk_slot_q;
  logic [7:0] chip_cfg_q;
  logic [7:0] chan_en_q;
  shcp_pkg::chan_mask_t enables;
  logic is_cmd;
  logic is_wdata;
  logic do_deact;
  logic do_act;
  logic do_soft_rst;
  logic do_hard_rst;

  // ***************************************************
  // helper functions
  // ***************************************************
  // base code with the direction bit masked off
  function automatic logic [7:0] cmd_base(input logic [7:0] cmd);
    cmd_base = cmd;
    cmd_base[`DIR_BIT] = 1'b0;
  endfunction

  // commands that carry one data byte in either direction
  function automatic logic has_data(input logic [7:0] cmd);
    logic [7:0] b;
    b = cmd_base(cmd);
    has_data = (b == `CMD_TX_SLOT) || (b == `CMD_RX_SLOT) || (b == `CMD_CLK_SLOT) ||
               (b == `CMD_CHIP_CFG) || (b == `CMD_CHAN_EN);
  endfunction

  // lowest enabled channel index, zero when none
  function automatic logic [1:0] lowest_chan(input shcp_pkg::chan_mask_t en);
    lowest_chan = 2'h0;
    for (int i = `CHANNELS - 1; i >= 0; i--) begin
      if (en[i]) begin
        lowest_chan = 2'(i);
      end
    end
  endfunction

  // ***************************************************
  // link domain: shift clock
  // ***************************************************
  // counters are cleared from the core side while select is high, so a
  // stopped shift clock never leaves a stale count behind
  always_ff @(posedge serial_shift_clock_i or posedge clear_q) begin
    if (clear_q) begin
      edge_cnt_q <= `EDGE_CNT_ZERO;
    end else if (!chip_select_n_i && edge_cnt_q != `EDGES_FOR_RESET) begin
      edge_cnt_q <= edge_cnt_q + 5'h01;
    end
  end

  // data register only; oldest bits fall off so the last eight remain
  always_ff @(posedge serial_shift_clock_i) begin
    if (!chip_select_n_i) begin
      shift_q <= {shift_q[6:0], serial_data_pin_i};
    end
  end

  // output bit advances on the falling edge after a sampling edge
  always_ff @(negedge serial_shift_clock_i or posedge clear_q) begin
    if (clear_q) begin
      bit_idx_q <= `BIT_IDX_ZERO;
    end else if (!chip_select_n_i && edge_cnt_q != `EDGE_CNT_ZERO &&
                 bit_idx_q != `BIT_IDX_LAST) begin
      bit_idx_q <= bit_idx_q + 3'h1;
    end
  end

  // select gates the driver directly: first bit stands before any edge
  assign serial_data_pin_oe_o = !chip_select_n_i && (state_q == shcp_pkg::ST_RDATA);
  assign serial_data_pin_o = tx_byte_q[`BIT_IDX_LAST - bit_idx_q];

  // ***************************************************
  // synchronisers and window end
  // ***************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= chip_select_n_i;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      fs_meta_q <= frame_sync_i;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
    end
  end

  assign win_end = cs_sync_q && !cs_prev_q;
  assign fs_rise = fs_sync_q && !fs_prev_q;

  // link counters are quasi-static here: select has been high two cycles
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      byte_valid_q <= 1'b0;
      byte_q <= `READ_EMPTY;
    end else begin
      byte_valid_q <= win_end && edge_cnt_q >= `EDGES_PER_BYTE &&
                      edge_cnt_q < `EDGES_FOR_RESET;
      if (win_end) begin
        byte_q <= shift_q;
      end
    end
  end
  assign byte_done = byte_valid_q;

  // a long window or the command both pulse the internal reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hard_rst_q <= 1'b0;
    end else begin
      hard_rst_q <= (win_end && edge_cnt_q >= `EDGES_FOR_RESET) || do_hard_rst;
    end
  end
  assign core_rst = rst_i || hard_rst_q;
  assign hard_reset_o = hard_rst_q;

  // hold the link counters cleared for a short spell after each window
  always_ff @(posedge ref_clk_i) begin
    if (core_rst || win_end) begin
      clear_q <= 1'b1;
      clear_cnt_q <= `CLEAR_HOLD_CYCLES;
    end else if (clear_cnt_q != 2'h0) begin
      clear_cnt_q <= clear_cnt_q - 2'h1;
    end else begin
      clear_q <= 1'b0;
    end
  end

  // ***************************************************
  // command sequencer
  // ***************************************************
  assign is_cmd = byte_done && state_q == shcp_pkg::ST_CMD;
  assign is_wdata = byte_done && state_q == shcp_pkg::ST_WDATA;
  assign do_deact = is_cmd && byte_q == `CMD_DEACTIVATE;
  assign do_act = is_cmd && byte_q == `CMD_ACTIVATE;
  assign do_soft_rst = is_cmd && byte_q == `CMD_SOFT_RESET;
  assign do_hard_rst = is_cmd && byte_q == `CMD_HARD_RESET;
  assign enables = chan_en_q[`CHAN_EN_MSB:`CHAN_EN_LSB];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      shcp_pkg::ST_CMD: begin
        // no-op and reserved codes take one window and do nothing
        if (byte_done && has_data(byte_q)) begin
          state_d = byte_q[`DIR_BIT] ? shcp_pkg::ST_RDATA : shcp_pkg::ST_WDATA;
        end
      end
      shcp_pkg::ST_WDATA: begin
        if (byte_done) begin
          state_d = shcp_pkg::ST_CMD;
        end
      end
      shcp_pkg::ST_RDATA: begin
        if (byte_done) begin
          state_d = shcp_pkg::ST_CMD;
        end
      end
      default: begin
        state_d = shcp_pkg::ST_CMD;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      state_q <= shcp_pkg::ST_CMD;
      cmd_q <= `CMD_NO_OP;
    end else begin
      state_q <= state_d;
      if (is_cmd) begin
        cmd_q <= byte_q;
      end
    end
  end

  // read byte is fixed while select is high, before the next window
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      tx_byte_q <= `READ_EMPTY;
    end else if (is_cmd && byte_q[`DIR_BIT] && has_data(byte_q)) begin
      unique case (cmd_base(byte_q))
        `CMD_TX_SLOT: tx_byte_q <= tts_q[lowest_chan(enables)];
        `CMD_RX_SLOT: tx_byte_q <= rts_q[lowest_chan(enables)];
        `CMD_CLK_SLOT: tx_byte_q <= (enables != 4'h0) ? clk_slot_q : `READ_EMPTY;
        `CMD_CHIP_CFG: tx_byte_q <= chip_cfg_q;
        default: tx_byte_q <= chan_en_q;
      endcase
    end
  end

  // ***************************************************
  // global configuration
  // ***************************************************
  // soft reset leaves all of these untouched
  always_ff @(posedge ref_clk_i) begin
    if (core_rst) begin
      clk_slot_q <= `CLK_SLOT_RST;
      chip_cfg_q <= `CHIP_CFG_RST;
      chan_en_q <= `CHAN_EN_RST;
    end else if (is_wdata) begin
      if (cmd_base(cmd_q) == `CMD_CLK_SLOT && enables != 4'h0) begin
        clk_slot_q <= byte_q;
      end
      if (cmd_base(cmd_q) == `CMD_CHIP_CFG) begin
        chip_cfg_q <= byte_q;
      end
      if (cmd_base(cmd_q) == `CMD_CHAN_EN) begin
        chan_en_q <= byte_q;
      end
    end
  end

  // ***************************************************
  // per-channel state
  // ***************************************************
  for (genvar c = 0; c < `CHANNELS; c++) begin : g_chan
    logic active_q;
    logic [1:0] fs_cnt_q;
    logic valid_q;

    // time slots survive a soft reset
    always_ff @(posedge ref_clk_i) begin
      if (core_rst) begin
        tts_q[c] <= 8'(c);
        rts_q[c] <= 8'(c);
      end else if (is_wdata && enables[c]) begin
        if (cmd_base(cmd_q) == `CMD_TX_SLOT) begin
          tts_q[c] <= byte_q;
        end
        if (cmd_base(cmd_q) == `CMD_RX_SLOT) begin
          rts_q[c] <= byte_q;
        end
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (core_rst) begin
        active_q <= 1'b0;
      end else if (enables[c]) begin
        if (do_act) begin
          active_q <= 1'b1;
        end else if (do_deact || do_soft_rst) begin
          active_q <= 1'b0;
        end
      end
    end

    // counts frame syncs after activation before pcm is declared valid
    always_ff @(posedge ref_clk_i) begin
      if (core_rst) begin
        fs_cnt_q <= 2'h0;
        valid_q <= 1'b0;
      end else if (enables[c] && (do_act || do_deact || do_soft_rst)) begin
        fs_cnt_q <= 2'h0;
        valid_q <= 1'b0;
      end else if (active_q && fs_rise) begin
        if (fs_cnt_q == `FS_PULSES_TO_VALID) begin
          valid_q <= 1'b1;
        end else begin
          fs_cnt_q <= fs_cnt_q + 2'h1;
        end
      end
    end

    assign channel_active_status_o[c] = active_q;
    assign pcm_input_enable_o[c] = active_q;
    assign analog_output_enable_o[c] = active_q;
    assign pcm_output_hiz_o[c] = !active_q && !chip_cfg_q[`SIGNALING_BIT];
    assign pcm_tx_valid_o[c] = valid_q;
  end

  assign tx_time_slot_o = tts_q;
  assign rx_time_slot_o = rts_q;
  assign clock_slot_cfg_o = clk_slot_q;
  assign chip_cfg_o = chip_cfg_q;
  assign chan_enable_mode_o = chan_en_q;

endmodule

//--- tb/shcp_asserts.sv
// checker on the ports of the serial host command port.
// assumes one core clock domain with the synchronous reset.
`timescale 1ns/10ps
module shcp_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_pin_oe_o,
  input wire shcp_pkg::slot_arr_t tx_time_slot_o,
  input wire logic [7:0] clock_slot_cfg_o,
  input wire logic [7:0] chip_cfg_o,
  input wire logic [7:0] chan_enable_mode_o,
  input wire shcp_pkg::chan_mask_t channel_active_status_o,
  input wire shcp_pkg::chan_mask_t pcm_input_enable_o,
  input wire shcp_pkg::chan_mask_t pcm_output_hiz_o,
  input wire shcp_pkg::chan_mask_t pcm_tx_valid_o,
  input wire shcp_pkg::chan_mask_t analog_output_enable_o,
  input wire logic hard_reset_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // ****************
  // properties
  // ****************
  property p_oe_window;
    serial_data_pin_oe_o |-> !chip_select_n_i;
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("pin driven when deselected");
  property p_reset_pulse;
    hard_reset_o |=> !hard_reset_o;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_reset_defaults;
    hard_reset_o |-> ##[1:2] (chip_cfg_o == 8'h9a && chan_enable_mode_o == 8'h0f &&
      clock_slot_cfg_o == 8'h00 && tx_time_slot_o == 32'h03020100 &&
      channel_active_status_o == 4'h0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not loaded");
  property p_pcm_in;
    pcm_input_enable_o == channel_active_status_o;
  endproperty
  a_pcm_in: assert property (p_pcm_in) else $error("pcm input enable wrong");
  property p_analog;
    analog_output_enable_o == channel_active_status_o;
  endproperty
  a_analog: assert property (p_analog) else $error("analog enable wrong");
  property p_hiz;
    pcm_output_hiz_o == (~channel_active_status_o & {4{~chip_cfg_o[5]}});
  endproperty
  a_hiz: assert property (p_hiz) else $error("pcm float wrong");
  property p_valid_active;
    (pcm_tx_valid_o & ~$past(pcm_tx_valid_o)) != 4'h0 |->
      (pcm_tx_valid_o & ~channel_active_status_o) == 4'h0;
  endproperty
  a_valid_active: assert property (p_valid_active) else $error("valid on idle channel");
  // settled updates land within five cycles of select rising
  property p_quiet;
    chip_select_n_i [*8] |=> $stable(chip_cfg_o) && $stable(tx_time_slot_o) &&
      $stable(chan_enable_mode_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("state moved while deselected");
  c_reset: cover property (hard_reset_o);
  c_read: cover property (serial_data_pin_oe_o);
  c_valid: cover property ($rose(pcm_tx_valid_o[1]));
endmodule
bind serial_host_command_port shcp_asserts chk (.ref_clk_i, .rst_i, .chip_select_n_i,
  .serial_data_pin_oe_o, .tx_time_slot_o, .clock_slot_cfg_o, .chip_cfg_o,
  .chan_enable_mode_o, .channel_active_status_o, .pcm_input_enable_o, .pcm_output_hiz_o,
  .pcm_tx_valid_o, .analog_output_enable_o, .hard_reset_o);

//--- tb/host_model.sv
// host side of the serial port: one select window per xfer call, none per spin.
// assumes the bench calls xfer and spin one at a time.
`timescale 1ns/10ps
module host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic oe_i
);
  // no pull on the pin: an undriven line shows the inverse, never a stale bit
  logic pin_seen;
  assign pin_seen = oe_i ? sdo_i : ~sdo_i;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
  end
  // n edges of d, msb first; r keeps the last eight bits, f the pin before any edge
  task automatic xfer(input logic [15:0] d, input int n, output logic [7:0] r,
                      output logic [1:0] f);
    cs_n_o = 1'b0;
    #40 f = {oe_i, pin_seen};
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = d[i];
      #80 sclk_o = 1'b1;
      r = {r[6:0], pin_seen};
      #80;
    end
    #40 cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line must not show a stale bit
    #200;
  endtask
  task automatic spin(input int n);
    repeat (n) begin
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial host command port.
// assumes host_model drives the link and the checker is bound.
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic frame_sync_i = 1'b0;
  logic sck, csn, sdi, sdo, oe, hr;
  shcp_pkg::slot_arr_t tts, rts;
  logic [7:0] cks, cfg, en, r;
  shcp_pkg::chan_mask_t act, pin, hiz, vld, aen;
  logic [1:0] f;
  int mismatches = 0;
  int compares = 0;
  int hr_cnt = 0;
  host_model hm (.sclk_o(sck), .cs_n_o(csn), .sdi_o(sdi), .sdo_i(sdo), .oe_i(oe));
  serial_host_command_port uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .serial_shift_clock_i(sck), .chip_select_n_i(csn), .serial_data_pin_i(sdi),
    .serial_data_pin_o(sdo), .serial_data_pin_oe_o(oe), .frame_sync_i(frame_sync_i),
    .tx_time_slot_o(tts), .rx_time_slot_o(rts), .clock_slot_cfg_o(cks), .chip_cfg_o(cfg),
    .chan_enable_mode_o(en), .channel_active_status_o(act), .pcm_input_enable_o(pin),
    .pcm_output_hiz_o(hiz), .pcm_tx_valid_o(vld), .analog_output_enable_o(aen),
    .hard_reset_o(hr));
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // ****************
  // helpers
  // ****************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    hm.xfer({8'h00, c}, 8, r, f);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd(c);
    hm.xfer({8'h00, d}, 8, r, f);
  endtask
  // counts internal reset pulses; hr is a one-cycle output
  always @(posedge ref_clk_i) begin
    if (hr === 1'b1) begin
      hr_cnt++;
    end
  end
  task automatic rd(input logic [7:0] c, input logic [7:0] exp, input string what);
    cmd(c);
    hm.xfer(16'h0000, 8, r, f);
    check(what, r, exp);
  endtask
  task automatic fs(input int n);
    repeat (n) begin
      @(negedge ref_clk_i) frame_sync_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      frame_sync_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check("cfg", cfg, 8'h9a);
    check("en", en, 8'h0f);
    check("tts", tts, 32'h03020100);
    check("hiz", hiz, 4'hf);
    $display("test defaults done");
    wr(8'h40, 8'h55);
    check("tts", tts, 32'h55555555);
    hm.spin(9);
    check("tts", tts, 32'h55555555);
    wr(8'h4a, 8'h06);
    check("en", en, 8'h06);
    wr(8'h42, 8'h3c);
    check("rts", rts, 32'h033c3c00);
    wr(8'h40, 8'h21);
    wr(8'h4a, 8'h0a);
    cmd(8'h41); // two channels enabled on purpose, against the advice
    hm.xfer(16'h0000, 8, r, f);
    check("first", f, 2'b10);
    check("read", r, 8'h21);
    $display("test write read done");
    cmd(8'h46);
    hm.xfer(16'h001f, 5, r, f);
    hm.xfer(16'h0f10, 12, r, f);
    check("cfg", cfg, 8'h10);
    wr(8'h46, 8'h20);
    check("hiz", hiz, 4'h0);
    $display("test framing done");
    cmd(8'h0e);
    check("act", act, 4'ha);
    check("pin", pin, 4'ha);
    fs(3);
    check("vld", vld, 4'h0);
    fs(1);
    check("vld", vld, 4'ha);
    cmd(8'h06);
    check("act", act, 4'ha);
    check("tts", tts, 32'h55212155);
    wr(8'h4a, 8'h02);
    rd(8'h43, 8'h3c, "rts read");
    cmd(8'h02);
    check("act", act, 4'h8);
    check("tts", tts, 32'h55212155);
    wr(8'h4a, 8'h0f);
    wr(8'h44, 8'h2d);
    check("cks", cks, 8'h2d);
    rd(8'h45, 8'h2d, "cks read");
    rd(8'h47, 8'h20, "cfg read");
    rd(8'h4b, 8'h0f, "en read");
    cmd(8'h00);
    check("act", act, 4'h0);
    check("pin", pin, 4'h0);
    check("aen", aen, 4'h0);
    check("cfg", cfg, 8'h20);
    $display("test states done");
    wr(8'h4a, 8'h00);
    wr(8'h44, 8'h11);
    check("cks", cks, 8'h2d);
    rd(8'h45, 8'h00, "cks no channel");
    cmd(8'h04);
    check("en", en, 8'h0f);
    check("hr", hr_cnt, 1);
    check("tts", tts, 32'h03020100);
    wr(8'h46, 8'h20);
    hm.xfer(16'hffff, 16, r, f);
    check("cfg", cfg, 8'h9a);
    check("cks", cks, 8'h00);
    check("hr", hr_cnt, 2);
    wr(8'h46, 8'h20);
    @(negedge ref_clk_i) rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check("cfg", cfg, 8'h9a);
    check("hr", hr_cnt, 2);
    $display("test resets done");
    give_verdict();
  end
endmodule
